// ===== logic/irx_pkg.sv
// shared constants and carrier types for the isochronous dma context control block
package irx_pkg;
    localparam int ADDR_W = 12;
    localparam int TX_CTX_N = 8;
    localparam int RX_CTX_N = 4;
    // register map, byte addresses
    localparam logic [ADDR_W-1:0] TXPTR_BASE = 12'h20C;
    localparam logic [ADDR_W-1:0] TXPTR_STRIDE = 12'h010;
    localparam logic [ADDR_W-1:0] RXCTL_SET_BASE = 12'h400;
    localparam logic [ADDR_W-1:0] RXCTL_CLR_BASE = 12'h404;
    localparam logic [ADDR_W-1:0] RXCTL_STRIDE = 12'h020;
    // receive context control field positions
    localparam int B_PACK = 31;
    localparam int B_HDR = 30;
    localparam int B_TSTART = 29;
    localparam int B_MULTI = 28;
    localparam int B_SPLIT = 27;
    localparam int B_RUN = 15;
    localparam int B_WAKE = 12;
    localparam int B_DEAD = 11;
    localparam int B_ACTIVE = 10;
    localparam int SPD_LO = 5;
    localparam logic [31:0] RXCTL_RESET = 32'h0000_0000;
    // isochronous header: channel field
    localparam int HDR_CH_LO = 8;
    localparam int CH_W = 6;
    localparam int CYC_W = 13;

    typedef struct packed {
        logic pack_fill_mode;
        logic header_retention;
        logic timed_start_enable;
        logic multichannel_reception;
        logic split_payload_mode;
        logic run;
        logic wake;
        logic dead;
        logic active;
        logic [2:0] spd;
    } irx_ctl_t;

    // one beat of a received packet from the link side
    typedef struct packed {
        logic valid;
        logic first;
        logic last;
        logic [2:0] speed;
        logic [31:0] data;
    } irx_beat_t;

    // cycle start packet seen by the link
    typedef struct packed {
        logic valid;
        logic [CYC_W-1:0] cycle;
        logic [15:0] stamp;
    } irx_cyc_t;

    // one quadlet written towards the receive buffers
    typedef struct packed {
        logic valid;
        logic [1:0] ctx;
        logic second;
        logic buf_end;
        logic last;
        logic [31:0] data;
    } irx_out_t;

    // control register image as software sees it
    function automatic logic [31:0] ctl_word(input irx_ctl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[B_PACK] = c.pack_fill_mode;
        w[B_HDR] = c.header_retention;
        w[B_TSTART] = c.timed_start_enable;
        w[B_MULTI] = c.multichannel_reception;
        w[B_SPLIT] = c.split_payload_mode;
        w[B_RUN] = c.run;
        w[B_WAKE] = c.wake;
        w[B_DEAD] = c.dead;
        w[B_ACTIVE] = c.active;
        w[SPD_LO+2:SPD_LO] = c.spd;
        return w;
    endfunction
endpackage

// ===== logic/irx_ptr_mem.sv
// small register-file memory holding the transmit descriptor pointers
`timescale 1ns/1ns
module irx_ptr_mem #(
    parameter int DEPTH = 8,
    parameter int W = 32,
    parameter int AW = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // read port, data one cycle after re
    input wire logic re,
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata_q
);
    logic [W-1:0] mem [DEPTH];

    // storage has no reset; software reads garbage before the first load
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read; a write in the same cycle shows on the next read
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= '0;
        end else if (re) begin
            rdata_q <= mem[raddr];
        end
    end
endmodule

// ===== logic/irx_ctx_sel.sv
// picks the receive context that takes a packet on a given channel
`timescale 1ns/1ns
module irx_ctx_sel
    import irx_pkg::*;
(
    // packet channel and per-context settings
    input wire logic [CH_W-1:0] chan,
    input wire irx_ctl_t [RX_CTX_N-1:0] ctl,
    input wire logic [RX_CTX_N-1:0][CH_W-1:0] match_chan,
    input wire logic [63:0] chan_mask,
    // result
    output logic hit,
    output logic [1:0] ctx
);
    // lowest numbered active context wins; several multichannel users are undefined
    always_comb begin
        hit = 1'b0;
        ctx = 2'h0;
        for (int i = RX_CTX_N - 1; i >= 0; i--) begin
            if (ctl[i].active && (ctl[i].multichannel_reception ? chan_mask[chan]
                    : (match_chan[i] == chan))) begin
                hit = 1'b1;
                ctx = 2'(i);
            end
        end
    end
endmodule

// ===== logic/irx_dma_ctl.sv
// isochronous dma context control: pointer readback, receive control, packet shaping
`timescale 1ns/1ns
module irx_dma_ctl
    import irx_pkg::*;
#(
    parameter int SPLIT_FIRST_Q = 2,
    parameter int BUF_Q = 256
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // transmit engine: first descriptor address at run
    input wire logic tx_ptr_load,
    input wire logic [2:0] tx_ptr_ctx,
    input wire logic [31:0] tx_ptr_addr,
    // receive engine events, one bit per context
    input wire logic [RX_CTX_N-1:0] desc_fetch,
    input wire logic [RX_CTX_N-1:0] fatal_err,
    // match and mask settings held elsewhere
    input wire logic [RX_CTX_N-1:0][CH_W-1:0] match_chan,
    input wire logic [RX_CTX_N-1:0][CYC_W-1:0] start_cycle_value,
    input wire logic [63:0] chan_mask,
    // link receive side
    input wire irx_beat_t link_beat,
    input wire irx_cyc_t cyc_start,
    output logic link_ready,
    // towards receive buffers
    output irx_out_t buf_out
);
    typedef struct packed {
        irx_ctl_t [RX_CTX_N-1:0] ctl;
        logic [31:0] rdata;
        logic rd_tx;
        logic busy;
        logic [1:0] ctx;
        logic [7:0] qcnt;
        logic trailer;
        logic [15:0] stamp;
        logic [RX_CTX_N-1:0][15:0] fill;
        logic ready;
        irx_out_t out;
    } irx_state_t;

    irx_state_t s_r;
    irx_state_t s_nxt;
    logic [ADDR_W-1:0] tx_off;
    logic [ADDR_W-1:0] rx_off;
    logic tx_hit;
    logic rx_hit;
    logic [1:0] rx_idx;
    logic [2:0] tx_idx;
    logic [31:0] mem_q;
    logic sel_hit;
    logic [1:0] sel_ctx;

    // address decode for both register groups
    always_comb begin
        tx_off = reg_addr - TXPTR_BASE;
        rx_off = reg_addr - RXCTL_SET_BASE;
        tx_idx = tx_off[6:4];
        rx_idx = rx_off[6:5];
        tx_hit = (reg_addr >= TXPTR_BASE) && (tx_off[3:0] == 4'h0)
            && (tx_off < TXPTR_STRIDE * 12'(TX_CTX_N));
        rx_hit = (reg_addr >= RXCTL_SET_BASE) && (rx_off < RXCTL_STRIDE * 12'(RX_CTX_N))
            && ((rx_off[4:0] == 5'h00) || (rx_off[4:0] == 5'h04));
    end

    // pointer captured when the transmit engine starts a context
    irx_ptr_mem #(
        .DEPTH(TX_CTX_N),
        .W(32),
        .AW(3)
    ) u_ptr_mem (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .we(tx_ptr_load),
        .waddr(tx_ptr_ctx),
        .wdata(tx_ptr_addr),
        .re(reg_rd && tx_hit),
        .raddr(tx_idx),
        .rdata_q(mem_q)
    );

    irx_ctx_sel u_sel (
        .chan(link_beat.data[HDR_CH_LO +: CH_W]),
        .ctl(s_r.ctl),
        .match_chan(match_chan),
        .chan_mask(chan_mask),
        .hit(sel_hit),
        .ctx(sel_ctx)
    );

    // software set or clear of one context control word
    function automatic irx_ctl_t sw_apply(input irx_ctl_t c, input logic [31:0] w,
            input logic set);
        irx_ctl_t r;
        logic [31:0] cur;
        logic [31:0] upd;
        r = c;
        cur = ctl_word(c);
        upd = set ? (cur | w) : (cur & ~w);
        r.pack_fill_mode = upd[B_PACK];
        r.header_retention = upd[B_HDR];
        r.timed_start_enable = upd[B_TSTART];
        r.multichannel_reception = upd[B_MULTI];
        r.run = upd[B_RUN];
        r.wake = set ? upd[B_WAKE] : c.wake;

        if (!(c.active || c.run)) begin
            r.split_payload_mode = upd[B_SPLIT];
        end

        if (r.split_payload_mode) begin
            r.multichannel_reception = 1'b0;
            r.pack_fill_mode = 1'b0;
        end

        if (c.run && !r.run) begin
            r.dead = 1'b0;
            r.active = 1'b0;
        end
        return r;
    endfunction

    // next state: registers, context sequencing, packet shaping
    always_comb begin
        logic e_valid;
        logic e_last;
        logic e_second;
        logic [31:0] e_data;
        logic [1:0] e_ctx;
        logic [15:0] f;
        logic sw_wake;
        irx_ctl_t c;
        logic [31:0] tw;
        e_valid = 1'b0;
        e_last = 1'b0;
        e_second = 1'b0;
        e_data = 32'h0000_0000;
        e_ctx = s_r.ctx;
        f = 16'h0000;
        sw_wake = 1'b0;
        c = s_r.ctl[0];
        tw = 32'h0000_0000;
        s_nxt = s_r;
        s_nxt.out.valid = 1'b0;
        s_nxt.out.last = 1'b0;
        s_nxt.out.buf_end = 1'b0;
        s_nxt.rd_tx = reg_rd && tx_hit;

        // register reads, reserved and unmapped return zero
        if (reg_rd) begin
            s_nxt.rdata = rx_hit ? ctl_word(s_r.ctl[rx_idx]) : 32'h0000_0000;
        end

        // per-context control: software first, hardware events after so sets win
        for (int i = 0; i < RX_CTX_N; i++) begin
            c = s_r.ctl[i];
            sw_wake = 1'b0;
            if (reg_wr && rx_hit && (rx_idx == 2'(i))) begin
                c = sw_apply(c, reg_wdata, rx_off[4:0] == 5'h00);
                sw_wake = (rx_off[4:0] == 5'h00) && reg_wdata[B_WAKE];
            end

            if (desc_fetch[i] && !sw_wake) begin
                c.wake = 1'b0;
            end

            if (fatal_err[i] && c.run) begin
                c.dead = 1'b1;
                c.active = 1'b0;
            end else if (c.run && !c.dead && !c.active) begin
                if (!c.timed_start_enable) begin
                    c.active = 1'b1;
                end else if (cyc_start.valid && (cyc_start.cycle == start_cycle_value[i])) begin
                    c.active = 1'b1;
                    c.timed_start_enable = 1'b0;
                end
            end

            s_nxt.ctl[i] = c;
        end

        // latest cycle start stamp for trailers
        if (cyc_start.valid) begin
            s_nxt.stamp = cyc_start.stamp;
        end

        // packet path
        if (s_r.trailer) begin
            // status and timestamp close a packet kept with its header
            e_valid = 1'b1;
            e_last = 1'b1;
            // status half taken from a temporary; a call result cannot be sliced
            // low half only: run, wake, dead, active and speed of the context
            tw = ctl_word(s_r.ctl[s_r.ctx]);
            e_data = {tw[15:0], s_r.stamp};
            s_nxt.trailer = 1'b0;
            s_nxt.ready = 1'b1;
        end else if (link_beat.valid && s_r.ready) begin
            if (link_beat.first) begin
                s_nxt.busy = sel_hit && !link_beat.last;
                s_nxt.ctx = sel_ctx;
                e_ctx = sel_ctx;
                s_nxt.qcnt = 8'h00;
                if (sel_hit) begin
                    s_nxt.ctl[sel_ctx].spd = link_beat.speed;
                    if (s_r.ctl[sel_ctx].header_retention) begin
                        e_valid = 1'b1;
                        e_data = link_beat.data;
                        s_nxt.trailer = link_beat.last;
                        s_nxt.ready = !link_beat.last;
                    end
                    // header dropped otherwise
                end
            end else if (s_r.busy) begin
                e_valid = 1'b1;
                e_data = link_beat.data;
                e_second = s_r.ctl[s_r.ctx].split_payload_mode
                    && (s_r.qcnt >= 8'(SPLIT_FIRST_Q));
                if (s_r.qcnt != 8'hFF) begin
                    s_nxt.qcnt = s_r.qcnt + 8'h01;
                end
                if (link_beat.last) begin
                    s_nxt.busy = 1'b0;
                    if (s_r.ctl[s_r.ctx].header_retention) begin
                        s_nxt.trailer = 1'b1;
                        s_nxt.ready = 1'b0; // one-beat stall for the trailer
                    end else begin
                        e_last = 1'b1;
                    end
                end
            end
        end

        // buffer accounting: packed fill closes on size, otherwise on each packet end
        if (e_valid) begin
            f = s_r.fill[e_ctx] + 16'h0001;
            s_nxt.out.valid = 1'b1;
            s_nxt.out.ctx = e_ctx;
            s_nxt.out.data = e_data;
            s_nxt.out.last = e_last;
            s_nxt.out.second = e_second;
            if (s_r.ctl[e_ctx].pack_fill_mode) begin
                s_nxt.out.buf_end = (f == 16'(BUF_Q));
                s_nxt.fill[e_ctx] = (f == 16'(BUF_Q)) ? 16'h0000 : f;
            end else begin
                s_nxt.out.buf_end = e_last;
                s_nxt.fill[e_ctx] = 16'h0000;
            end
        end
    end

    // single state register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.ready <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs; pointer reads come from the memory's own read register
    assign reg_rdata = s_r.rd_tx ? mem_q : s_r.rdata;
    assign link_ready = s_r.ready;
    assign buf_out = s_r.out;

    // usage notes for whoever integrates this block
    //
    // register port
    // - reads answer in the cycle after the strobe, never stretched
    // - control reads and pointer reads come from two registers
    // - the final select between them is the only logic after a flop
    // - unmapped addresses read zero and swallow writes
    // - pointer addresses are read only; writes there are dropped

    // context control
    // - software set and clear land first, hardware events after them
    // - so a fatal error in the same cycle as a set still sets dead
    // - a wake set by software beats a descriptor fetch in that cycle
    // - clearing run drops active and dead together
    // - split mode is frozen while run or active, old value kept
    // - split mode forces pack fill and multichannel low at every write

    // timed start
    // - compares only the cycle count, not the seconds bits
    // - the enable falls on the same edge that raises active
    // - a context waiting for its cycle takes no packets

    // channel selection
    // - lowest numbered active context wins a shared channel
    // - two multichannel users give no error, only the lowest one
    // - software must keep to one multichannel user

    // packet shaping
    // - header kept only with header retention, else dropped
    // - a kept header costs one stall cycle for the trailer
    // - trailer carries the low status half and the latest stamp
    // - the stamp is whatever cycle start came last, even mid packet
    // - split point is a fixed quadlet count, not a byte count
    // - the second part is only marked, the buffers lie downstream

    // buffer accounting
    // - pack fill counts quadlets per context, closes at the size
    // - without pack fill every packet end closes its buffer
    // - the counter saturates nowhere; size must fit sixteen bits
    // - a packet cut by a full buffer continues in the next one

    // limits
    // - payload index saturates at 255 quadlets for the split test
    // - longer packets keep streaming into the second part
    // - pointer storage has no reset and reads unknown until loaded
    // - the link side must hold a beat until ready is seen high
    // - beats offered during the trailer stall are simply not taken
endmodule

// ===== testbench/irx_dma_ctl_props.sv
// port-level checks for the receive control block
`timescale 1ns/1ns
module irx_dma_ctl_props
    import irx_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // link and buffer side
    input wire irx_beat_t link_beat,
    input wire logic link_ready,
    input wire irx_out_t buf_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // marks the cycle where control read data stand
    logic ctl_rd_r;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl_rd_r <= 1'b0;
        end else begin
            ctl_rd_r <= reg_rd && reg_addr >= RXCTL_SET_BASE;
        end
    end
    // steps of a packet end with header retention
    sequence s_take;
        link_beat.valid && link_ready;
    endsequence
    sequence s_trailer;
        link_ready && buf_out.valid && buf_out.last;
    endsequence
    property p_rsvd_zero;
        ctl_rd_r |-> reg_rdata[26:16] == 11'h000;
    endproperty
    property p_split_force;
        ctl_rd_r && reg_rdata[B_SPLIT] |-> !reg_rdata[B_PACK] && !reg_rdata[B_MULTI];
    endproperty
    property p_dead_run;
        ctl_rd_r && reg_rdata[B_DEAD] |-> reg_rdata[B_RUN];
    endproperty
    property p_active_run;
        ctl_rd_r && reg_rdata[B_ACTIVE] |-> reg_rdata[B_RUN] && !reg_rdata[B_TSTART];
    endproperty
    property p_spd_code;
        ctl_rd_r |-> reg_rdata[9:7] == 3'h0;
    endproperty
    property p_unmapped;
        reg_rd && reg_addr == 12'h000 |=> reg_rdata == 32'h0000_0000;
    endproperty
    // trailer cycle has no beat behind it, hence the second term
    property p_out_cause;
        buf_out.valid |-> $past(link_beat.valid && link_ready) || $past(!link_ready);
    endproperty
    property p_trailer;
        s_take ##1 $fell(link_ready) |=> s_trailer;
    endproperty
    property p_one_gap;
        !link_ready |=> link_ready;
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");
    a_split_force: assert property (p_split_force) else $error("split kept pack");
    a_dead_run: assert property (p_dead_run) else $error("dead without run");
    a_active_run: assert property (p_active_run) else $error("active state bad");
    a_spd_code: assert property (p_spd_code) else $error("speed code bad");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    a_out_cause: assert property (p_out_cause) else $error("stray output");
    a_trailer: assert property (p_trailer) else $error("no trailer");
    a_one_gap: assert property (p_one_gap) else $error("long stall");
endmodule

bind irx_dma_ctl irx_dma_ctl_props u_props (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .link_beat(link_beat),
    .link_ready(link_ready),
    .buf_out(buf_out)
);

// ===== testbench/irx_link_src.sv
// link receive side model: packet beats and cycle start pulses
`timescale 1ns/1ns
module irx_link_src
    import irx_pkg::*;
(
    // clock
    input wire logic ref_clk,
    // beat handshake and cycle start
    input wire logic link_ready,
    output irx_beat_t link_beat,
    output irx_cyc_t cyc_start
);
    // idle at time zero
    initial begin
        link_beat = '0;
        cyc_start = '0;
    end
    // one beat, held until taken or for at most 20 cycles; idle data inverted so nothing stale looks valid
    task automatic beat(input logic f, input logic l, input logic [2:0] s, input logic [31:0] d);
        int k;
        repeat ($urandom_range(2)) @(posedge ref_clk);
        @(posedge ref_clk);
        link_beat <= '{1'b1, f, l, s, d};
        for (k = 0; k < 20; k++) begin
            @(posedge ref_clk);
            if (link_ready === 1'b1) break;
        end
        link_beat <= '{1'b0, 1'b0, 1'b0, ~s, ~d};
    endtask
    // header beat then n payload quadlets counting up from base
    task automatic send(input logic [5:0] ch, input int n, input logic [2:0] s,
            input logic [31:0] base);
        int i;
        beat(1'b1, 1'b0, s, {18'h0, ch, 8'h00});
        for (i = 0; i < n; i++) begin
            beat(1'b0, i == n - 1, s, base + 32'(i));
        end
    endtask
    // single cycle start pulse
    task automatic cyc(input logic [12:0] c, input logic [15:0] st);
        @(posedge ref_clk);
        cyc_start <= '{1'b1, c, st};
        @(posedge ref_clk);
        cyc_start <= '{1'b0, ~c, ~st};
    endtask
endmodule

// ===== testbench/test_irx_dma_ctl.sv
// self-checking bench for the isochronous dma context control block
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_irx_dma_ctl;
    import irx_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic tx_ptr_load = 1'b0;
    logic [2:0] tx_ptr_ctx = '0;
    logic [31:0] tx_ptr_addr = '0;
    logic [RX_CTX_N-1:0] desc_fetch = '0;
    logic [RX_CTX_N-1:0] fatal_err = '0;
    logic [RX_CTX_N-1:0][CH_W-1:0] match_chan = {6'h03, 6'h02, 6'h05, 6'h07};
    logic [RX_CTX_N-1:0][CYC_W-1:0] start_cycle_value = {4{13'h0123}};
    logic [63:0] chan_mask = 64'h0000_0000_0000_0200;
    irx_beat_t link_beat;
    irx_cyc_t cyc_start;
    logic link_ready;
    irx_out_t buf_out;
    int num_errors = 0;
    int total_checks = 0;
    logic rd_d = 1'b0;
    logic [31:0] exp_rd[$];
    irx_out_t exp_out[$];
    logic [31:0] exp_rd_w;
    irx_out_t exp_out_w;
    logic [31:0] v;
    int i;
    always #20 ref_clk = ~ref_clk;
    irx_dma_ctl #(.SPLIT_FIRST_Q(2), .BUF_Q(4)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_ptr_load(tx_ptr_load), .tx_ptr_ctx(tx_ptr_ctx),
        .tx_ptr_addr(tx_ptr_addr), .desc_fetch(desc_fetch), .fatal_err(fatal_err),
        .match_chan(match_chan), .start_cycle_value(start_cycle_value),
        .chan_mask(chan_mask), .link_beat(link_beat), .cyc_start(cyc_start),
        .link_ready(link_ready), .buf_out(buf_out));
    irx_link_src u_src (.ref_clk(ref_clk), .link_ready(link_ready),
        .link_beat(link_beat), .cyc_start(cyc_start));
    // monitor: oldest note against each result as it appears
    always @(posedge ref_clk) begin
        rd_d <= reg_rd;
        // pop once into a holder; the macro reads its arguments twice
        if (rd_d && exp_rd.size() > 0) begin
            exp_rd_w = exp_rd.pop_front();
            `CHK(reg_rdata, exp_rd_w)
        end
        if (buf_out.valid !== 1'b0) begin
            `CHK(exp_out.size() > 0, 1'b1)
            if (exp_out.size() > 0) begin
                exp_out_w = exp_out.pop_front();
                `CHK(buf_out, exp_out_w)
            end
        end
    end
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    function automatic logic [11:0] ca(input int n, input logic clr);
        return (clr ? RXCTL_CLR_BASE : RXCTL_SET_BASE) + 12'(n) * RXCTL_STRIDE;
    endfunction
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
    endtask
    task automatic ex(input logic [1:0] c, input logic s, input logic be, input logic l,
            input logic [31:0] d);
        exp_out.push_back('{1'b1, c, s, be, l, d});
    endtask
    task automatic pulse(input logic f, input logic [3:0] m);
        @(posedge ref_clk);
        if (f) fatal_err <= m; else desc_fetch <= m;
        @(posedge ref_clk);
        fatal_err <= '0;
        desc_fetch <= '0;
    endtask
    // bounded wait until every note is matched
    task automatic drain(input string nm);
        int k;
        for (k = 0; k < 80 && exp_rd.size() + exp_out.size() > 0; k++) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
        if (exp_rd.size() + exp_out.size() > 0) begin
            num_errors++;
            $display("[ERR] %0t timeout in %s", $time, nm);
            tally_and_finish();
        end else begin
            $display("test %s done", nm);
        end
    endtask
    initial begin
        void'($urandom(32'hBF392A8A));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i++) begin
            rd(ca(i, 0), 32'h0);
            rd(ca(i, 1), 32'h0);
        end
        rd(12'h000, 32'h0);
        drain("reset");
        for (i = 0; i < 8; i++) begin
            v = $urandom();
            @(posedge ref_clk);
            tx_ptr_load <= 1'b1;
            tx_ptr_ctx <= 3'(i);
            tx_ptr_addr <= v;
            @(posedge ref_clk);
            tx_ptr_load <= 1'b0;
            wr(TXPTR_BASE + 12'(i) * TXPTR_STRIDE, ~v);
            rd(TXPTR_BASE + 12'(i) * TXPTR_STRIDE, v);
        end
        drain("pointers");
        wr(ca(1, 0), 32'hC000_1000);
        rd(ca(1, 1), 32'hC000_1000);
        pulse(1'b0, 4'h2);
        rd(ca(1, 0), 32'hC000_0000);
        wr(ca(1, 1), 32'h8000_0000);
        rd(ca(1, 0), 32'h4000_0000);
        wr(ca(0, 0), 32'h9800_0000); // split mode only touched while idle
        rd(ca(0, 0), 32'h0800_0000);
        wr(ca(0, 0), 32'h0000_8000);
        rd(ca(0, 0), 32'h0800_8400);
        wr(ca(0, 1), 32'h0800_0000);
        rd(ca(0, 0), 32'h0800_8400);
        pulse(1'b1, 4'h1);
        rd(ca(0, 0), 32'h0800_8800);
        wr(ca(0, 1), 32'h0800_8000);
        rd(ca(0, 0), 32'h0800_0000);
        drain("control");
        wr(ca(2, 0), 32'h2000_8000);
        u_src.cyc(13'h0122, 16'h1111);
        rd(ca(2, 0), 32'h2000_8000);
        u_src.cyc(13'h0123, 16'hBEEF);
        rd(ca(2, 0), 32'h0000_8400);
        drain("timed start");
        wr(ca(1, 0), 32'h0000_8000);
        v = $urandom();
        ex(2'd1, 1'b0, 1'b0, 1'b0, {18'h0, 6'h05, 8'h00});
        for (i = 0; i < 3; i++) ex(2'd1, 1'b0, 1'b0, 1'b0, v + 32'(i));
        ex(2'd1, 1'b0, 1'b1, 1'b1, 32'h8460_BEEF);
        u_src.send(6'h05, 3, 3'b011, v);
        rd(ca(1, 0), 32'h4000_8460);
        u_src.send(6'h06, 2, 3'b000, v);
        wr(ca(0, 0), 32'h0000_8000);
        for (i = 0; i < 3; i++) ex(2'd0, i == 2, i == 2, i == 2, v + 32'(i));
        u_src.send(6'h07, 3, 3'b001, v);
        wr(ca(3, 0), 32'h9000_8000);
        for (i = 0; i < 5; i++) ex(2'd3, 1'b0, i == 3, i == 4, v + 32'(i));
        u_src.send(6'h09, 5, 3'b010, v);
        u_src.send(6'h03, 2, 3'b010, v);
        drain("packets");
        tally_and_finish();
    end
endmodule
